// ---- rtl/acc_top.sv ----
// control and status logic of an analog voltage comparator, one 8-bit register over APB
// assumes the analog core gives an asynchronous output level and takes enable and mux controls
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`include "acc_map.svh"

module acc_top #(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              resetn,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // analog comparator core
   input  wire logic              cmp_raw,
   output logic                   cmp_power_on,
   output logic                   cmp_low_power,
   output logic                   cmp_pos_bandgap,
   output logic                   cmp_neg_from_pin,
   // power and debug modes of the processor
   input  wire logic              wait_mode,
   input  wire logic              stop3_mode,
   input  wire logic              stop12_mode,
   input  wire logic              debug_active,
   // output pin
   output logic                   comparator_output_pin,
   output logic                   comparator_output_pin_oe,
   // interrupt request
   output logic                   cmp_irq,
   // timer capture routing
   input  wire logic              capture_route_select,
   input  wire logic              capture0_pin_in,
   output logic                   capture0_in
);

   if (ADDR_W < 3 || ADDR_W > 32)
   begin : g_bad_addr_w
      $error("acc_top address width must be 3 to 32 bits");
   end

   // the settle count below is two bits wide
   if (`ACC_SYNC_STAGES > 2)
   begin : g_bad_sync_stages
      $error("acc_top settle count cannot cover that many sync stages");
   end

   // reset image of the register; the writable fields take their reset values from it
   localparam logic [7:0] SC_RESET = `ACC_SC_RESET;

   // reset release through two flip-flops
   logic rst_meta_ff;
   logic rst_sync_ff;
   logic rst_n;

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end
      else
      begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   assign rst_n = rst_sync_ff;

   // power mode tracking
   acc_pkg::acc_pwr_e pwr_ff;
   acc_pkg::acc_pwr_e nxt_pwr;
   logic              run_clk;
   logic              powered_down;

   always_comb
   begin
      if (stop12_mode)
         nxt_pwr = acc_pkg::ACC_OFF;
      else if (stop3_mode)
         nxt_pwr = acc_pkg::ACC_STOP3;
      else if (wait_mode)
         nxt_pwr = acc_pkg::ACC_WAIT;
      else
         nxt_pwr = acc_pkg::ACC_RUN;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         pwr_ff <= acc_pkg::ACC_RUN;
      else
         pwr_ff <= nxt_pwr;
   end

   // debug mode has no effect: run and debug are treated alike
   always_comb
   begin
      unique case (pwr_ff)
         acc_pkg::ACC_RUN:
         begin
            run_clk      = 1'b1;
            powered_down = 1'b0;
         end
         acc_pkg::ACC_WAIT:
         begin
            run_clk      = 1'b1;
            powered_down = 1'b0;
         end
         acc_pkg::ACC_STOP3:
         begin
            run_clk      = 1'b0;
            powered_down = 1'b0;
         end
         acc_pkg::ACC_OFF:
         begin
            run_clk      = 1'b0;
            powered_down = 1'b1;
         end
      endcase
   end

   // bus decode
   logic sel_sc;
   logic bus_wr;
   logic bus_rd_setup;
   logic wr_take;

   assign sel_sc       = (paddr == ADDR_W'(`ACC_SC_OFFSET));
   assign bus_wr       = psel && penable && pwrite && sel_sc && pready;
   assign bus_rd_setup = psel && !penable && !pwrite;
   // writes are dropped while the module clock is halted
   assign wr_take      = bus_wr && run_clk;
   assign pready       = 1'b1;
   assign pslverr      = psel && penable && !sel_sc;

   // control fields
   logic       enable_ff;
   logic       refsel_ff;
   logic       ie_ff;
   logic       pinen_ff;
   logic [1:0] mode_ff;
   logic       flag_ff;
   logic       nxt_flag;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         enable_ff <= SC_RESET[`ACC_BIT_ENABLE];
         refsel_ff <= SC_RESET[`ACC_BIT_REFSEL];
         ie_ff     <= SC_RESET[`ACC_BIT_IE];
         pinen_ff  <= SC_RESET[`ACC_BIT_PINEN];
         mode_ff   <= SC_RESET[`ACC_MODE_HI:`ACC_MODE_LO];
      end
      else if (powered_down)
      begin
         enable_ff <= SC_RESET[`ACC_BIT_ENABLE];
         refsel_ff <= SC_RESET[`ACC_BIT_REFSEL];
         ie_ff     <= SC_RESET[`ACC_BIT_IE];
         pinen_ff  <= SC_RESET[`ACC_BIT_PINEN];
         mode_ff   <= SC_RESET[`ACC_MODE_HI:`ACC_MODE_LO];
      end
      else if (wr_take)
      begin
         enable_ff <= pwdata[`ACC_BIT_ENABLE];
         refsel_ff <= pwdata[`ACC_BIT_REFSEL];
         ie_ff     <= pwdata[`ACC_BIT_IE];
         pinen_ff  <= pwdata[`ACC_BIT_PINEN];
         mode_ff   <= pwdata[`ACC_MODE_HI:`ACC_MODE_LO];
      end
   end

   // comparator output synchronised; cleared while disabled
   logic active;
   logic cmp_sync;

   assign active = enable_ff && run_clk;

   acc_sync #(
      .STAGES (`ACC_SYNC_STAGES)
   ) u_sync (
      .mclk  (mclk),
      .rst_n (rst_n),
      .clear (!enable_ff || powered_down),
      .hold  (!run_clk),
      .d     (cmp_raw),
      .q     (cmp_sync)
   );

   // previous sample and a settle count: after enable or stop3 exit the synchroniser
   // still holds stale levels, so edges wait until it has refilled with fresh samples
   localparam logic [1:0] ARM_DONE = 2'(`ACC_SYNC_STAGES + 1);
   logic       prev_ff;
   logic [1:0] arm_cnt_ff;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prev_ff    <= 1'b0;
         arm_cnt_ff <= 2'h0;
      end
      else if (!active)
      begin
         prev_ff    <= cmp_sync;
         arm_cnt_ff <= 2'h0;
      end
      else
      begin
         prev_ff <= cmp_sync;
         if (arm_cnt_ff != ARM_DONE)
            arm_cnt_ff <= arm_cnt_ff + 2'h1;
      end
   end

   function automatic logic edge_hit(input logic [1:0] mode, input logic prev, input logic cur);
      logic rise;
      logic fall;
      rise = !prev && cur;
      fall = prev && !cur;
      unique case (acc_pkg::acc_mode_e'(mode))
         acc_pkg::ACC_FALL_A: edge_hit = fall;
         acc_pkg::ACC_RISE:   edge_hit = rise;
         acc_pkg::ACC_FALL_B: edge_hit = fall;
         acc_pkg::ACC_TOGGLE: edge_hit = rise || fall;
      endcase
   endfunction : edge_hit

   logic event_hit;

   assign event_hit = active && (arm_cnt_ff == ARM_DONE)
                      && edge_hit(mode_ff, prev_ff, cmp_sync);

   // flag: an event in the clearing cycle wins
   always_comb
   begin
      nxt_flag = flag_ff;
      if (wr_take && pwdata[`ACC_BIT_FLAG])
         nxt_flag = 1'b0;
      if (event_hit)
         nxt_flag = 1'b1;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         flag_ff <= SC_RESET[`ACC_BIT_FLAG];
      else if (powered_down)
         flag_ff <= SC_RESET[`ACC_BIT_FLAG];
      else
         flag_ff <= nxt_flag;
   end

   // interrupt: stays off in stop so it cannot wake the part
   assign cmp_irq = flag_ff && ie_ff && run_clk;

   // read data, taken in the setup cycle
   logic [7:0] sc_value;

   assign sc_value = {enable_ff, refsel_ff, flag_ff, ie_ff,
                      cmp_sync && enable_ff, pinen_ff, mode_ff};

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         prdata <= 32'h0000_0000;
      else if (bus_rd_setup)
         prdata <= sel_sc ? {24'h00_0000, sc_value} : 32'h0000_0000;
   end

   // analog controls
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmp_power_on    <= 1'b0;
         cmp_low_power   <= 1'b0;
         cmp_pos_bandgap <= 1'b0;
      end
      else
      begin
         cmp_power_on    <= enable_ff && !powered_down;
         cmp_low_power   <= (nxt_pwr == acc_pkg::ACC_STOP3);
         cmp_pos_bandgap <= refsel_ff;
      end
   end

   assign cmp_neg_from_pin = 1'b1;

   // output pin and capture route
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         comparator_output_pin    <= 1'b0;
         comparator_output_pin_oe <= 1'b0;
      end
      else
      begin
         comparator_output_pin    <= pinen_ff && enable_ff && cmp_sync && !powered_down;
         comparator_output_pin_oe <= pinen_ff;
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         capture0_in <= 1'b0;
      else
         capture0_in <= capture_route_select ? cmp_sync : capture0_pin_in;
   end

   // debug_active only documents that nothing changes in background mode
   logic unused_debug;

   assign unused_debug = debug_active;

endmodule : acc_top

// ---- rtl/acc_map.svh ----
// register map, field positions, reset values and timing counts of the comparator control
// assumes an APB slave with 32-bit data, the register in the low byte of one word
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

`define ACC_SC_OFFSET     12'h000
`define ACC_SC_RESET      8'h00
`define ACC_SC_WMASK      8'hF7

`define ACC_BIT_ENABLE    7
`define ACC_BIT_REFSEL    6
`define ACC_BIT_FLAG      5
`define ACC_BIT_IE        4
`define ACC_BIT_OUT       3
`define ACC_BIT_PINEN     2
`define ACC_MODE_HI       1
`define ACC_MODE_LO       0

`define ACC_SYNC_STAGES   2
`define ACC_CLK_PERIOD_NS 100
`define ACC_APB_WAIT      0

`endif

// ---- rtl/acc_pkg.sv ----
// types shared by the comparator control files
// assumes acc_map.svh for numbers; this package holds types only
package acc_pkg;

   typedef enum logic [1:0]
   {
      ACC_FALL_A,
      ACC_RISE,
      ACC_FALL_B,
      ACC_TOGGLE
   } acc_mode_e;

   typedef enum logic [1:0]
   {
      ACC_RUN,
      ACC_WAIT,
      ACC_STOP3,
      ACC_OFF
   } acc_pwr_e;

endpackage : acc_pkg

// ---- rtl/acc_sync.sv ----
// level synchroniser with hold and clear, used for the raw comparator output
// assumes the input is asynchronous to mclk and rst_n is already synchronised
`timescale 1ns/100ps

module acc_sync #(
   parameter int STAGES = 2
) (
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst_n,
   // control
   input  wire logic clear,
   input  wire logic hold,
   // data
   input  wire logic d,
   output logic      q
);

   logic [STAGES-1:0] stage_ff;

   // the edge detector needs a settled second stage
   if (STAGES < 2)
   begin : g_bad_stages
      $error("acc_sync needs at least two stages");
   end

   // first stage feeds only the second stage
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         stage_ff <= '0;
      else if (clear)
         stage_ff <= '0;
      else if (!hold)
         stage_ff <= {stage_ff[STAGES-2:0], d};
   end

   assign q = stage_ff[STAGES-1];

endmodule : acc_sync

// ---- test/acc_properties.sv ----
// concurrent checks on the ports of the comparator control block
// assumes it is bound into acc_top; internal reset ends two edges after resetn
`timescale 1ns/100ps

module acc_checker #(
   parameter int ADDR_W = 12
) (
   // clock, reset and bus
   input wire logic              mclk,
   input wire logic              resetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   // core and modes
   input wire logic              cmp_power_on,
   input wire logic              cmp_low_power,
   input wire logic              cmp_pos_bandgap,
   input wire logic              cmp_neg_from_pin,
   input wire logic              stop3_mode,
   input wire logic              stop12_mode,
   // pin, request, capture
   input wire logic              comparator_output_pin,
   input wire logic              comparator_output_pin_oe,
   input wire logic              cmp_irq,
   input wire logic              capture_route_select,
   input wire logic              capture0_pin_in,
   input wire logic              capture0_in
);
   logic wr_ok;

   default clocking @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   // a register write that must land
   assign wr_ok = psel && penable && pwrite && paddr == '0 && !stop3_mode && !stop12_mode;

   property p_en; wr_ok |=> ##1 cmp_power_on == $past(pwdata[7], 2); endproperty
   a_en: assert property (p_en) else $error("enable write lost");
   property p_ref; wr_ok |=> ##1 cmp_pos_bandgap == $past(pwdata[6], 2); endproperty
   a_ref: assert property (p_ref) else $error("reference select lost");
   property p_mask; wr_ok && !pwdata[4] |=> !cmp_irq; endproperty
   a_mask: assert property (p_mask) else $error("masked request seen");
   property p_off; psel && penable && !pwrite && !prdata[7] |-> !prdata[3]; endproperty
   a_off: assert property (p_off) else $error("output bit set while off");
   property p_pin; comparator_output_pin |-> comparator_output_pin_oe && cmp_power_on;
   endproperty
   a_pin: assert property (p_pin) else $error("pin driven while disabled");
   property p_neg; cmp_neg_from_pin; endproperty
   a_neg: assert property (p_neg) else $error("inverting input not from pin");
   property p_stop3; stop3_mode [*2] |-> cmp_low_power && !cmp_irq; endproperty
   a_stop3: assert property (p_stop3) else $error("core active in stop3");
   property p_stop12; stop12_mode [*3] |-> !cmp_power_on && !cmp_irq; endproperty
   a_stop12: assert property (p_stop12) else $error("core alive in stop1/2");
   property p_cap; !capture_route_select |=> capture0_in == $past(capture0_pin_in);
   endproperty
   a_cap: assert property (p_cap) else $error("capture pin not passed");

   c_wr: cover property (wr_ok);
   c_irq: cover property (cmp_irq);
   c_stop3: cover property (stop3_mode [*2]);
endmodule : acc_checker

// ---- test/acc_cmp_model.sv ----
// behavioural analog comparator core facing the control block
// assumes pin voltages in millivolts and an output that settles at once
`timescale 1ns/100ps

module acc_cmp_model #(
   parameter logic [11:0] BG_MV = 12'h4B0
) (
   // controls from the block
   input  wire logic        cmp_power_on,
   input  wire logic        cmp_low_power,
   input  wire logic        cmp_pos_bandgap,
   input  wire logic        cmp_neg_from_pin,
   // pin voltages
   input  wire logic [11:0] pos_mv,
   input  wire logic [11:0] neg_mv,
   // level to the block
   output logic             cmp_raw
);
   logic [11:0] non_inv;

   assign non_inv = cmp_pos_bandgap ? BG_MV : pos_mv;
   // an unpowered or low power core sits low
   assign cmp_raw = cmp_power_on && !cmp_low_power && cmp_neg_from_pin
                    && non_inv > neg_mv;
endmodule : acc_cmp_model

// ---- test/acc_tb_top.sv ----
// self-checking bench for the comparator control block with a core model
// assumes acc_top, acc_checker and acc_cmp_model are compiled first
`timescale 1ns/100ps

module acc_tb_top;
   logic        mclk, resetn, psel, penable, pwrite, pready, pslverr, se;
   logic        cmp_raw, cmp_power_on, cmp_low_power, cmp_pos_bandgap, cmp_neg_from_pin;
   logic        wait_mode, stop3_mode, stop12_mode, debug_active, cmp_irq;
   logic        comparator_output_pin, comparator_output_pin_oe;
   logic        capture_route_select, capture0_pin_in, capture0_in;
   logic [11:0] paddr, pos_mv, neg_mv;
   logic [31:0] pwdata, prdata, rd;
   int          error_cnt = 0;
   int          cmp_count = 0;

   acc_top #(
      .ADDR_W (12)
   ) i_dut (
      .mclk (mclk), .resetn (resetn), .psel (psel), .penable (penable),
      .pwrite (pwrite), .paddr (paddr), .pwdata (pwdata), .prdata (prdata),
      .pready (pready), .pslverr (pslverr), .cmp_raw (cmp_raw),
      .cmp_power_on (cmp_power_on), .cmp_low_power (cmp_low_power),
      .cmp_pos_bandgap (cmp_pos_bandgap), .cmp_neg_from_pin (cmp_neg_from_pin),
      .wait_mode (wait_mode), .stop3_mode (stop3_mode), .stop12_mode (stop12_mode),
      .debug_active (debug_active), .comparator_output_pin (comparator_output_pin),
      .comparator_output_pin_oe (comparator_output_pin_oe), .cmp_irq (cmp_irq),
      .capture_route_select (capture_route_select), .capture0_pin_in (capture0_pin_in),
      .capture0_in (capture0_in)
   );
   acc_cmp_model i_core (
      .cmp_power_on (cmp_power_on), .cmp_low_power (cmp_low_power),
      .cmp_pos_bandgap (cmp_pos_bandgap), .cmp_neg_from_pin (cmp_neg_from_pin),
      .pos_mv (pos_mv), .neg_mv (neg_mv), .cmp_raw (cmp_raw)
   );

   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
      @(posedge mclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h000000, d};
      @(posedge mclk);
      penable <= 1'b1;
      do
      begin
         @(posedge mclk);
      end
      while (pready !== 1'b1);
      rd      = prdata;
      se      = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd_chk(input string what, input logic [7:0] exp);
      apb(12'h000, 1'b0, 8'h00);
      chk(what, {24'h000000, exp}, rd);
   endtask : rd_chk

   task automatic t_modes;
      debug_active <= 1'b1;
      for (int m = 0; m < 4; m++)
      begin
         apb(12'h000, 1'b1, 8'hA4 | 8'(m));
         repeat (6) @(posedge mclk);
         apb(12'h000, 1'b1, 8'hA4 | 8'(m));
         pos_mv <= 12'h300;
         repeat (6) @(posedge mclk);
         rd_chk("rise", {2'b10, m == 1 || m == 3, 3'b011, m[1:0]});
         chk("output pin", 32'h1, comparator_output_pin);
         chk("pin enable", 32'h1, comparator_output_pin_oe);
         chk("masked request", 32'h0, cmp_irq);
         apb(12'h000, 1'b1, 8'hA4 | 8'(m));
         pos_mv <= 12'h100;
         repeat (6) @(posedge mclk);
         rd_chk("fall", {2'b10, m != 1, 3'b001, m[1:0]});
      end
      $display("modes test done");
   endtask : t_modes

   task automatic t_irq;
      // comparator stays enabled across wait because wait keeps the module clock running, as in run
      wait_mode <= 1'b1;
      apb(12'h000, 1'b1, 8'hB3);
      repeat (6) @(posedge mclk);
      apb(12'h000, 1'b1, 8'hB3);
      pos_mv <= 12'h300;
      repeat (6) @(posedge mclk);
      chk("request in wait", 32'h1, cmp_irq);
      apb(12'h000, 1'b1, 8'h93);
      @(posedge mclk);
      chk("flag after zero write", 32'h1, cmp_irq);
      apb(12'h000, 1'b1, 8'hB3);
      @(posedge mclk);
      chk("flag after one write", 32'h0, cmp_irq);
      wait_mode <= 1'b0;
      $display("request test done");
   endtask : t_irq

   task automatic t_ref;
      pos_mv <= 12'h100;
      apb(12'h000, 1'b1, 8'hE0);
      repeat (6) @(posedge mclk);
      apb(12'h000, 1'b1, 8'hE0);
      rd_chk("bandgap high", 8'hC8);
      chk("capture from pin", 32'h0, capture0_in);
      capture_route_select <= 1'b1;
      repeat (3) @(posedge mclk);
      chk("capture from output", 32'h1, capture0_in);
      capture_route_select <= 1'b0;
      neg_mv <= 12'h600;
      repeat (6) @(posedge mclk);
      rd_chk("bandgap low", 8'hE0);
      neg_mv <= 12'h200;
      $display("reference test done");
   endtask : t_ref

   task automatic t_off;
      pos_mv <= 12'h300;
      apb(12'h000, 1'b1, 8'h24);
      repeat (6) @(posedge mclk);
      rd_chk("disabled", 8'h04);
      chk("pin while off", 32'h0, comparator_output_pin);
      $display("disable test done");
   endtask : t_off

   task automatic t_stop;
      apb(12'h000, 1'b1, 8'hB3);
      repeat (6) @(posedge mclk);
      apb(12'h000, 1'b1, 8'hB3);
      stop3_mode <= 1'b1;
      repeat (2) @(posedge mclk);
      pos_mv <= 12'h100;
      repeat (6) @(posedge mclk);
      chk("low power", 32'h1, cmp_low_power);
      stop3_mode <= 1'b0;
      repeat (6) @(posedge mclk);
      rd_chk("after stop3", 8'h93);
      stop12_mode <= 1'b1;
      repeat (4) @(posedge mclk);
      stop12_mode <= 1'b0;
      repeat (4) @(posedge mclk);
      rd_chk("after stop12", 8'h00);
      $display("stop test done");
   endtask : t_stop

   task automatic t_bus;
      rd_chk("reset value", 8'h00);
      apb(12'h004, 1'b1, 8'hFF);
      apb(12'h004, 1'b0, 8'h00);
      chk("unmapped error", 32'h1, se);
      chk("unmapped data", 32'h0, rd);
      rd_chk("untouched", 8'h00);
      $display("bus test done");
   endtask : t_bus

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test

   initial
   begin
      {resetn, psel, penable, pwrite, wait_mode, stop3_mode, stop12_mode} = '0;
      {debug_active, capture_route_select, capture0_pin_in} = '0;
      paddr = '0;
      pwdata = '0;
      pos_mv = 12'h100;
      neg_mv = 12'h200;
      repeat (10) @(posedge mclk);
      resetn <= 1'b1;
      repeat (3) @(posedge mclk);
      t_bus();
      t_modes();
      t_irq();
      t_ref();
      t_off();
      t_stop();
      stop_test();
   end

   initial
   begin
      #300000;
      error_cnt++;
      stop_test();
   end
endmodule : acc_tb_top

bind acc_top acc_checker #(
   .ADDR_W (ADDR_W)
) i_chk (
   .mclk (mclk), .resetn (resetn), .psel (psel), .penable (penable), .pwrite (pwrite),
   .paddr (paddr), .pwdata (pwdata), .prdata (prdata), .cmp_power_on (cmp_power_on),
   .cmp_low_power (cmp_low_power), .cmp_pos_bandgap (cmp_pos_bandgap),
   .cmp_neg_from_pin (cmp_neg_from_pin), .stop3_mode (stop3_mode),
   .stop12_mode (stop12_mode), .comparator_output_pin (comparator_output_pin),
   .comparator_output_pin_oe (comparator_output_pin_oe), .cmp_irq (cmp_irq),
   .capture_route_select (capture_route_select), .capture0_pin_in (capture0_pin_in),
   .capture0_in (capture0_in)
);
